// [rtl/rrc_pkg.sv]
// Package with the types and constants of the rotate-right-through-link datapath slice.
package rrc_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned MSB_POS = 7;
   localparam int unsigned LSB_POS = 0;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic LINK_RESET = 1'h0;
   localparam logic MSB_RESET = 1'h0;
   localparam logic ZERO_RESET = 1'h0;
   localparam logic WR_EN_RESET = 1'h0;
   localparam logic [7:0] WR_DATA_RESET = 8'h00;
   localparam logic TARGET_ACC = 1'h0;
   localparam logic TARGET_FILE = 1'h1;

   typedef struct packed {
      logic       rotate_right_link_op;
      logic       target_sel;
      logic [7:0] operand;
   } rrc_req_t;

   typedef struct packed {
      logic       write_en;
      logic [7:0] data;
   } rrc_file_wr_t;

   typedef struct packed {
      logic link;
      logic msb;
      logic zero;
   } rrc_flags_t;
endpackage

// [rtl/rrc_core.sv]
// Rotate-right-through-link datapath slice with accumulator and status flags.
module rrc_core
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire rrc_pkg::rrc_req_t req,
   output rrc_pkg::rrc_file_wr_t  file_wr,
   output logic [7:0]             acc,
   output rrc_pkg::rrc_flags_t    flags
);

   wire logic [7:0] next_result;
   logic            link;
   logic            msb;
   logic            zero;
   logic            result_zero;
   logic            take_acc;
   logic            take_file;
   logic            wr_en;
   logic [7:0]      wr_data;

   // Each result bit takes its upper neighbour from the operand; only the top bit differs.
   for (genvar bit_idx = 0; bit_idx < rrc_pkg::DATA_W; bit_idx++)
   begin : g_rotate
      if (bit_idx == rrc_pkg::MSB_POS)
      begin : g_top
         // The link flag is read before this edge's update, so the old value fills the top bit.
         assign next_result[bit_idx] = link;
      end
      else
      begin : g_low
         assign next_result[bit_idx] = req.operand[bit_idx + 1];
      end
   end

   always_comb
   begin
      take_acc  = 1'h0;
      take_file = 1'h0;
      if (req.rotate_right_link_op)
      begin
         unique case (req.target_sel)
            rrc_pkg::TARGET_ACC:
            begin
               take_acc = 1'h1;
            end
            rrc_pkg::TARGET_FILE:
            begin
               take_file = 1'h1;
            end
         endcase
      end
   end

   always_comb
   begin
      result_zero = (next_result == rrc_pkg::ZERO_BYTE);
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         link <= rrc_pkg::LINK_RESET;
      end
      else if (req.rotate_right_link_op)
      begin
         link <= req.operand[rrc_pkg::LSB_POS];
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         msb <= rrc_pkg::MSB_RESET;
      end
      else if (req.rotate_right_link_op)
      begin
         msb <= next_result[rrc_pkg::MSB_POS];
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         zero <= rrc_pkg::ZERO_RESET;
      end
      else if (req.rotate_right_link_op)
      begin
         zero <= result_zero;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         acc <= rrc_pkg::ACC_RESET;
      end
      else if (take_acc)
      begin
         acc <= next_result;
      end
   end

   // The write strobe is registered so that it lines up with its data for the file.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_en <= rrc_pkg::WR_EN_RESET;
      end
      else
      begin
         wr_en <= take_file;
      end
   end

   // The data follows the rotator every cycle, saving a load enable; only the strobe marks a write.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_data <= rrc_pkg::WR_DATA_RESET;
      end
      else
      begin
         wr_data <= next_result;
      end
   end

   always_comb
   begin
      flags.link       = link;
      flags.msb        = msb;
      flags.zero       = zero;
      file_wr.write_en = wr_en;
      file_wr.data     = wr_data;
   end

endmodule

// [testbench/rrc_core_assertions.sv]
// Concurrent checks on the ports of the rotate slice.
module rrc_chk
(
   input wire logic                  clk,
   input wire logic                  rstn,
   input wire rrc_pkg::rrc_req_t     req,
   input wire rrc_pkg::rrc_file_wr_t file_wr,
   input wire logic [7:0]            acc,
   input wire rrc_pkg::rrc_flags_t   flags
);
   timeunit 1ns;
   timeprecision 1ps;
   wire       o = req.rotate_right_link_op, t = req.target_sel;
   wire       k = flags.link, w = file_wr.write_en;
   wire [7:0] d = req.operand, r = file_wr.data;
   default clocking c @(posedge clk); endclocking
   default disable iff (!rstn);
   a_low_bits: assert property (o |=> r[6:0] == $past(d[7:1])) else $error("shift");
   a_link_pass: assert property (o |=> {r[7], k} == $past({k, d[0]})) else $error("link");
   a_acc_dest: assert property (o && !t |=> acc == r && !w) else $error("acc");
   a_file_dest: assert property (o && t |=> w && $stable(acc)) else $error("wb");
   a_flag_set: assert property (o |=> flags[1:0] == {r[7], !r}) else $error("nz");
   cover property (o && t);
   cover property (o && !t);
   cover property (o ##1 r == 8'h00);
endmodule

// [testbench/tb.sv]
// Random bench of the rotate slice with a few fixed corner cases.
`define CK(a, b) \
   total_checks++; \
   if ((a) !== (b)) \
   begin \
      err_total++; \
      $display("[ERR] %0t output mismatch", $time); \
   end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  clk = 1'h0;
   logic                  rstn = 1'h0;
   logic                  l = 1'h0;
   logic                  m = 1'h0;
   logic                  z = 1'h0;
   logic [7:0]            acc;
   logic [7:0]            a = 8'h00;
   logic [7:0]            r = 8'h00;
   int unsigned           s = 24;
   rrc_pkg::rrc_req_t     req = '0;
   rrc_pkg::rrc_file_wr_t fw;
   rrc_pkg::rrc_flags_t   fl;
   int                    err_total = 0;
   int                    total_checks = 0;
   rrc_core rrc_core_inst (.clk(clk), .rstn(rstn), .req(req), .file_wr(fw), .acc(acc),
      .flags(fl));
   function automatic logic [9:0] xs();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s[9:0];
   endfunction
   // Expected rotate: the link held before the op fills the top bit.
   function automatic logic [7:0] rot_exp(input logic lk, input logic [7:0] v);
      return {lk, v[7:1]};
   endfunction
   // The link flag is carried from op to op, so ops are sent back to back on purpose.
   // Bit 9 of v is the op strobe, so about half the cycles are idle and must hold flags and acc; the file data still follows the rotator.
   task automatic drive(input logic [9:0] v);
      req = v;
      r = rot_exp(l, v[7:0]);
      if (v[9])
      begin
         l = v[0];
         m = r[7];
         z = (r == 8'h00);
         a = v[8] ? a : r;
      end
      @(negedge clk);
      `CK(fl, {l, m, z})
      `CK({fw, acc}, {v[9] & v[8], r, a})
   endtask
   task automatic pulse_reset();
      rstn = 1'h0;
      req = '0;
      l = 1'h0;
      m = 1'h0;
      z = 1'h0;
      a = 8'h00;
      @(negedge clk);
      `CK(fl, 3'h0)
      `CK({fw, acc}, 17'h00000)
      @(negedge clk);
      rstn = 1'h1;
   endtask
   task automatic tally_and_finish(input int late);
      err_total += late;
      if (err_total == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial forever #2 clk = ~clk;
   initial #2000 tally_and_finish(1);
   initial
   begin
      repeat (12) @(negedge clk);
      rstn = 1'h1;
      drive(10'h3E6);
      drive(10'h201);
      drive(10'h200);
      drive(10'h0FF);
      drive(10'h1FF);
      repeat (99) drive(xs());
      pulse_reset();
      drive(10'h3E6);
      repeat (40) drive(xs());
      tally_and_finish(0);
   end
endmodule
bind rrc_core rrc_chk rrc_chk_inst (.clk(clk), .rstn(rstn), .req(req), .file_wr(file_wr),
   .acc(acc), .flags(flags));
